// File: pkg/uib_pkg.sv
// uart interrupt, reset-state and baud generator constants and carriers
// assumes one 20 MHz clock; fifo data path and serialisers sit outside
package uib_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 50;

  // interrupt identification codes
  localparam logic [5:0] IIR_NONE = 6'h01;
  localparam logic [5:0] IIR_LINE = 6'h06;
  localparam logic [5:0] IIR_TIMEOUT = 6'h0C;
  localparam logic [5:0] IIR_RXDATA = 6'h04;
  localparam logic [5:0] IIR_TXEMPTY = 6'h02;
  localparam logic [5:0] IIR_MODEM = 6'h08;
  localparam logic [5:0] IIR_FLOWCHR = 6'h10;
  localparam logic [5:0] IIR_PINCHG = 6'h20;

  // irq_enable_reg bit positions
  localparam int IER_RXDATA = 0;
  localparam int IER_TXEMPTY = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam int IER_FLOWCHR = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;

  // control bit positions
  localparam int LCR_BREAK = 6;
  localparam int MCR_PRESCALE = 7;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  localparam int DLF_RATE8 = 7;
  localparam int DLF_FRAC_W = 6;

  // line_status_reg bit positions
  localparam int LSR_DATA = 0;
  localparam int LSR_OVERRUN = 1;
  localparam int LSR_ERR_LO = 2;
  localparam int LSR_THR_EMPTY = 5;
  localparam int LSR_TX_EMPTY = 6;
  localparam int LSR_FIFO_ERR = 7;

  // pin reset states
  localparam logic RST_TX = 1'b1;
  localparam logic RST_RTS_N = 1'b1;
  localparam logic RST_DTR_N = 1'b1;
  localparam logic RST_RX_RDY_N = 1'b1;
  localparam logic RST_TX_RDY_N = 1'b0;

  // timing counts
  localparam logic [5:0] WORD_BASE = 6'h05;
  localparam logic [5:0] TIMEOUT_EXTRA = 6'h0C;
  localparam logic [3:0] OVS_16_LAST = 4'hF;
  localparam logic [3:0] OVS_8_LAST = 4'h7;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // configuration from the host side
  typedef struct packed {
    logic [7:0] irq_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] divisor_fraction;
    logic fifo_en;
  } uib_cfg_t;

  // receive fifo status and events
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] trigger;
    logic [2:0] head_err;
    logic push;
    logic push_err;
    logic pop;
    logic overrun;
    logic line;
  } uib_rx_t;

  // transmit side status
  typedef struct packed {
    logic serial;
    logic holding_empty;
    logic shift_empty;
    logic trig;
    logic full;
  } uib_tx_t;

  // flow and modem events, one-cycle pulses except pins
  typedef struct packed {
    logic pause_det;
    logic resume_det;
    logic special_det;
    logic [3:0] modem_change;
    logic cts_n;
    logic rts_n;
  } uib_evt_t;

  // registers that survive reset
  typedef struct packed {
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] scratch;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
  } uib_keep_t;

  // host write strobes for kept registers
  typedef struct packed {
    logic [6:0] sel;
    logic [7:0] data;
  } uib_wr_t;

endpackage : uib_pkg

// File: design/uib_baud_gen.sv
// baud generator: prescaler, 16-bit integer divisor, 1/64 fraction
// assumes the divisor is stable while the line is in use
`timescale 1ns/1ps
module uib_baud_gen
  import uib_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // settings
  input wire logic [15:0] i_divisor,
  input wire logic [DLF_FRAC_W-1:0] i_frac,
  input wire logic i_rate8,
  input wire logic i_prescale,
  // ticks
  output logic o_tick,
  output logic o_bit
);

  typedef struct packed {
    logic [1:0] pre_cnt;
    logic [15:0] div_cnt;
    logic [DLF_FRAC_W-1:0] acc;
    logic [3:0] ovs_cnt;
    logic tick;
    logic bit_tick;
  } uib_bg_t;

  uib_bg_t st_reg;
  uib_bg_t st_next;
  logic pre_ok;
  logic [DLF_FRAC_W:0] acc_sum;
  logic [3:0] ovs_last;

  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.bit_tick = 1'b0;
    pre_ok = !i_prescale || (st_reg.pre_cnt == PRESCALE_LAST);
    acc_sum = {1'b0, st_reg.acc} + {1'b0, i_frac};
    ovs_last = i_rate8 ? OVS_8_LAST : OVS_16_LAST;
    st_next.pre_cnt = st_reg.pre_cnt + 2'h1;
    if (i_divisor == 16'h0000)
    begin
      // zero divisor parks the generator
      st_next = '0;
    end
    else if (pre_ok)
    begin
      // a lowered divisor cuts a long count short instead of waiting it out
      if (st_reg.div_cnt == 16'h0000 || st_reg.div_cnt > i_divisor)
      begin
        // the fraction carry stretches one period by a cycle
        st_next.acc = acc_sum[DLF_FRAC_W-1:0];
        st_next.div_cnt = i_divisor - 16'h0001 + {15'h0000, acc_sum[DLF_FRAC_W]};
        st_next.tick = 1'b1;
        if (st_reg.ovs_cnt >= ovs_last)
        begin
          st_next.ovs_cnt = 4'h0;
          st_next.bit_tick = 1'b1;
        end
        else
        begin
          st_next.ovs_cnt = st_reg.ovs_cnt + 4'h1;
        end
      end
      else
      begin
        st_next.div_cnt = st_reg.div_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_tick = st_reg.tick;
  assign o_bit = st_reg.bit_tick;

  chk_zero_div_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_divisor == 16'h0000) |=> !st_reg.tick)
    else $error("baud tick with zero divisor");

  chk_div_one_rate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_divisor == 16'h0001 && i_frac == '0 && !i_prescale)[*3] |-> st_reg.tick)
    else $error("divisor one does not tick every cycle");

endmodule : uib_baud_gen

// File: design/uib_uart_ctrl.sv
// uart control core: reset pin states, kept registers, seven-level interrupt
// priority, line status summary, receive timeout, break and baud generator
// assumes fifo, serialisers and host decode sit outside and give pulses
// Operation
// - divisor, scratch and four flow characters are untouched by reset
// - reset drives transmit, rts, dtr, rx dma ready high, tx dma ready low
// - seven prioritised interrupt types, each enabled, irq only for enabled pending
// - ident field gives top pending type; 000001 means nothing pending
// - line status code 000110 from errors; overrun cleared by status read
// - timeout code 001100 shows stale receive data, cleared by holding read
// - receive data code 000100 on data ready or above trigger
// - transmit code 000010 on empty or trigger; ident read or write clears
// - flow character code 010000; resume clears pause, ident read clears special
// - code 100000 on rts or cts going high; ident read clears
// - fifo error summary set while any stored character has an error
// - per-character error bits follow fifo head, zero when fifo empty
// - any of enable bits 3:0 means interrupt mode, else host polls; enable bits 5-7 also raise irq here
// - timeout after line high for four word lengths plus twelve bits
// - break control bit forces serial transmit output low
// - divisor integer 1 to 65535 with fraction in 1/64 steps
// - top fraction bit picks 8x or 16x output rate
// - top modem control bit inserts divide-by-4 prescaler
// - zero divisor gives no baud clock and an idle uart
// - one generator clocks both transmitter and receiver
// - clearing enable bits 0-3 and 5-7 silences the interrupt output
`timescale 1ns/1ps
module uib_uart_ctrl
  import uib_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // configuration
  input wire uib_cfg_t i_cfg,
  input wire uib_wr_t i_wr,
  // host read and write pulses
  input wire logic i_rd_iir,
  input wire logic i_rd_lsr,
  input wire logic i_rd_msr,
  input wire logic i_rd_rhr,
  input wire logic i_wr_thr,
  // data path status
  input wire uib_rx_t i_rx,
  input wire uib_tx_t i_tx,
  input wire uib_evt_t i_evt,
  // pins
  output logic o_tx,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_rx_dma_ready_n,
  output logic o_tx_dma_ready_n,
  output logic o_irq,
  // status
  output logic [5:0] o_irq_ident,
  output logic [7:0] o_line_status,
  output logic [3:0] o_modem_delta,
  output uib_keep_t o_keep,
  // baud ticks for both serialisers
  output logic o_baud_tick,
  output logic o_bit_tick
);

  typedef struct packed {
    logic tx;
    logic rts_n;
    logic dtr_n;
    logic rx_rdy_n;
    logic tx_rdy_n;
    logic irq;
    logic [5:0] ident;
    logic [7:0] line_status_reg;
    logic overrun;
    logic [7:0] err_cnt;
    logic timeout;
    logic [5:0] to_cnt;
    logic thr_irq;
    logic thr_prev;
    logic [3:0] msr_delta;
    logic pause_irq;
    logic special_irq;
    logic rts_chg;
    logic cts_chg;
    logic rts_prev;
    logic cts_prev;
  } uib_state_t;

  localparam uib_state_t ST_RESET = '{
    tx: RST_TX,
    rts_n: RST_RTS_N,
    dtr_n: RST_DTR_N,
    rx_rdy_n: RST_RX_RDY_N,
    tx_rdy_n: RST_TX_RDY_N,
    irq: 1'b0,
    ident: IIR_NONE,
    line_status_reg: 8'h00,
    overrun: 1'b0,
    err_cnt: 8'h00,
    timeout: 1'b0,
    to_cnt: 6'h00,
    thr_irq: 1'b0,
    thr_prev: 1'b0,
    msr_delta: 4'h0,
    pause_irq: 1'b0,
    special_irq: 1'b0,
    rts_chg: 1'b0,
    cts_chg: 1'b0,
    rts_prev: 1'b1,
    cts_prev: 1'b1
  };

  uib_state_t st_reg;
  uib_state_t st_next;
  uib_keep_t keep_reg;
  uib_keep_t keep_next;
  logic baud_tick;
  logic bit_tick;
  logic rx_nonempty;
  logic rx_data_p;
  logic thr_cond;
  logic [5:0] to_lim;
  logic [7:0] irq_enable_reg;
  logic p_line;
  logic p_to;
  logic p_rd;
  logic p_tx;
  logic p_ms;
  logic p_fc;
  logic p_pc;
  logic iir_clr;

  // single generator shared by both directions
  uib_baud_gen u_baud (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_divisor({keep_reg.divisor_high, keep_reg.divisor_low}),
    .i_frac(i_cfg.divisor_fraction[DLF_FRAC_W-1:0]),
    .i_rate8(i_cfg.divisor_fraction[DLF_RATE8]),
    .i_prescale(i_cfg.modem_control[MCR_PRESCALE]),
    .o_tick(baud_tick),
    .o_bit(bit_tick)
  );

  // kept registers: no reset term so the host setup survives
  always_comb
  begin
    keep_next = keep_reg;
    if (i_wr.sel[0])
      keep_next.divisor_low = i_wr.data;
    if (i_wr.sel[1])
      keep_next.divisor_high = i_wr.data;
    if (i_wr.sel[2])
      keep_next.scratch = i_wr.data;
    if (i_wr.sel[3])
      keep_next.resume_char_one = i_wr.data;
    if (i_wr.sel[4])
      keep_next.resume_char_two = i_wr.data;
    if (i_wr.sel[5])
      keep_next.pause_char_one = i_wr.data;
    if (i_wr.sel[6])
      keep_next.pause_char_two = i_wr.data;
  end

  always_ff @(posedge i_clk)
  begin
    keep_reg <= keep_next;
  end

  always_comb
  begin
    st_next = st_reg;
    irq_enable_reg = i_cfg.irq_enable;
    rx_nonempty = (i_rx.level != 8'h00);
    iir_clr = i_rd_iir;

    // pins
    st_next.tx = i_tx.serial & ~i_cfg.line_control[LCR_BREAK];
    st_next.rts_n = ~i_cfg.modem_control[MCR_RTS];
    st_next.dtr_n = ~i_cfg.modem_control[MCR_DTR];
    st_next.rx_rdy_n = ~rx_nonempty;
    st_next.tx_rdy_n = i_tx.full;

    // overrun: a new event wins over the status read
    if (i_rd_lsr)
      st_next.overrun = 1'b0;
    if (i_rx.overrun)
      st_next.overrun = 1'b1;

    // erroneous characters held in the fifo
    if (i_rx.push && i_rx.push_err && !(i_rx.pop && i_rx.head_err != 3'h0))
      st_next.err_cnt = st_reg.err_cnt + 8'h01;
    else if (!(i_rx.push && i_rx.push_err) && i_rx.pop && i_rx.head_err != 3'h0
             && st_reg.err_cnt != 8'h00)
      st_next.err_cnt = st_reg.err_cnt - 8'h01;

    // receive timeout, counted in bit times while the line idles high
    to_lim = ((WORD_BASE + {4'h0, i_cfg.line_control[1:0]}) << 2) + TIMEOUT_EXTRA;
    // a holding read restarts the count; the flag is raised only when the count first reaches the limit
    if (!i_rx.line || !rx_nonempty || i_rx.pop || i_rd_rhr)
      st_next.to_cnt = 6'h00;
    else if (bit_tick && st_reg.to_cnt != to_lim)
      st_next.to_cnt = st_reg.to_cnt + 6'h01;
    if (i_rd_rhr)
      st_next.timeout = 1'b0;
    if (st_next.to_cnt == to_lim && st_reg.to_cnt != to_lim)
      st_next.timeout = 1'b1;

    // transmit: raised on the rising edge of the empty or trigger condition
    thr_cond = i_cfg.fifo_en ? i_tx.trig : i_tx.holding_empty;
    st_next.thr_prev = thr_cond;
    if (i_wr_thr || (iir_clr && st_reg.ident == IIR_TXEMPTY))
      st_next.thr_irq = 1'b0;
    if (thr_cond && !st_reg.thr_prev)
      st_next.thr_irq = 1'b1;

    // modem change bits
    if (i_rd_msr)
      st_next.msr_delta = 4'h0;
    st_next.msr_delta = st_next.msr_delta | i_evt.modem_change;

    // flow character interrupt, two causes cleared differently
    if (i_evt.resume_det)
      st_next.pause_irq = 1'b0;
    if (i_evt.pause_det)
      st_next.pause_irq = 1'b1;
    if (iir_clr && st_reg.ident == IIR_FLOWCHR)
      st_next.special_irq = 1'b0;
    if (i_evt.special_det)
      st_next.special_irq = 1'b1;

    // rts and cts going from active low to inactive high
    st_next.rts_prev = i_evt.rts_n;
    st_next.cts_prev = i_evt.cts_n;
    if (iir_clr && st_reg.ident == IIR_PINCHG)
    begin
      st_next.rts_chg = 1'b0;
      st_next.cts_chg = 1'b0;
    end
    if (i_evt.rts_n && !st_reg.rts_prev)
      st_next.rts_chg = 1'b1;
    if (i_evt.cts_n && !st_reg.cts_prev)
      st_next.cts_chg = 1'b1;

    // line status; head error bits blank on an empty fifo
    st_next.line_status_reg = 8'h00;
    st_next.line_status_reg[LSR_DATA] = rx_nonempty;
    st_next.line_status_reg[LSR_OVERRUN] = st_next.overrun;
    st_next.line_status_reg[LSR_ERR_LO +: 3] = rx_nonempty ? i_rx.head_err : 3'h0;
    st_next.line_status_reg[LSR_THR_EMPTY] = i_tx.holding_empty;
    st_next.line_status_reg[LSR_TX_EMPTY] = i_tx.shift_empty;
    st_next.line_status_reg[LSR_FIFO_ERR] = (st_next.err_cnt != 8'h00);

    // enabled pending sources
    rx_data_p = i_cfg.fifo_en ? (i_rx.level > i_rx.trigger) : rx_nonempty;
    p_line = irq_enable_reg[IER_LINE] & (st_reg.overrun | st_reg.line_status_reg[LSR_FIFO_ERR]);
    p_to = irq_enable_reg[IER_RXDATA] & st_reg.timeout;
    p_rd = irq_enable_reg[IER_RXDATA] & rx_data_p;
    p_tx = irq_enable_reg[IER_TXEMPTY] & st_reg.thr_irq;
    p_ms = irq_enable_reg[IER_MODEM] & (st_reg.msr_delta != 4'h0);
    p_fc = irq_enable_reg[IER_FLOWCHR] & (st_reg.pause_irq | st_reg.special_irq);
    p_pc = (irq_enable_reg[IER_RTS] & st_reg.rts_chg) | (irq_enable_reg[IER_CTS] & st_reg.cts_chg);

    // priority, highest first
    if (p_line)
      st_next.ident = IIR_LINE;
    else if (p_to)
      st_next.ident = IIR_TIMEOUT;
    else if (p_rd)
      st_next.ident = IIR_RXDATA;
    else if (p_tx)
      st_next.ident = IIR_TXEMPTY;
    else if (p_ms)
      st_next.ident = IIR_MODEM;
    else if (p_fc)
      st_next.ident = IIR_FLOWCHR;
    else if (p_pc)
      st_next.ident = IIR_PINCHG;
    else
      st_next.ident = IIR_NONE;
    // all enables clear leaves the output quiet: polled mode
    st_next.irq = p_line | p_to | p_rd | p_tx | p_ms | p_fc | p_pc;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_reg <= ST_RESET;
    else
      st_reg <= st_next;
  end

  assign o_tx = st_reg.tx;
  assign o_rts_n = st_reg.rts_n;
  assign o_dtr_n = st_reg.dtr_n;
  assign o_rx_dma_ready_n = st_reg.rx_rdy_n;
  assign o_tx_dma_ready_n = st_reg.tx_rdy_n;
  assign o_irq = st_reg.irq;
  assign o_irq_ident = st_reg.ident;
  assign o_line_status = st_reg.line_status_reg;
  assign o_modem_delta = st_reg.msr_delta;
  assign o_keep = keep_reg;
  assign o_baud_tick = baud_tick;
  assign o_bit_tick = bit_tick;

  chk_reset_pin_state: assert property (@(posedge i_clk)
    !i_nrst |-> (o_tx && o_rts_n && o_dtr_n && o_rx_dma_ready_n && !o_tx_dma_ready_n))
    else $error("pin state wrong during reset");

  chk_break_forces_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg.line_control[LCR_BREAK] |=> !o_tx)
    else $error("break did not force transmit low");

  chk_irq_all_disabled: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg.irq_enable == 8'h00)[*2] |-> !o_irq)
    else $error("interrupt while all enables clear");

  chk_ident_none_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_irq_ident == IIR_NONE) == !o_irq)
    else $error("ident code disagrees with interrupt output");

  chk_overrun_set_wins: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rx.overrun && i_rd_lsr) |=> o_line_status[LSR_OVERRUN])
    else $error("overrun lost against status read");

  chk_overrun_read_clr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd_lsr && !i_rx.overrun) |=> !o_line_status[LSR_OVERRUN])
    else $error("overrun not cleared by status read");

  chk_head_err_empty: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rx.level == 8'h00) |=> (o_line_status[LSR_ERR_LO +: 3] == 3'h0))
    else $error("error bits set on empty fifo");

  chk_line_top_prio: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg.irq_enable[IER_LINE] && st_reg.overrun) |=> (o_irq_ident == IIR_LINE))
    else $error("line status not reported first");

  chk_timeout_rhr_clr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rd_rhr |=> !st_reg.timeout)
    else $error("timeout not cleared by holding read");

  chk_pin_rise_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!st_reg.cts_prev && i_evt.cts_n) |=> st_reg.cts_chg)
    else $error("cts rise not flagged");

  chk_modem_pending: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_evt.modem_change != 4'h0 && i_cfg.irq_enable[IER_MODEM]) |-> ##2 o_irq)
    else $error("modem change raised no interrupt");

endmodule : uib_uart_ctrl

// File: verification/uib_peer_model.sv
// far-side model: receive fifo status and serial line seen by the control core
// assumes bench pulses push, push_err, pop and overrun for one cycle each
`timescale 1ns/1ps
module uib_peer_model
  import uib_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // bench commands
  input wire logic i_push,
  input wire logic i_push_err,
  input wire logic i_pop,
  input wire logic i_overrun,
  input wire logic i_line,
  // status to the core
  output uib_rx_t o_rx
);
  logic [7:0] level_reg;
  logic err_reg;
  // head error only while something is stored, parity flavour
  always_comb
  begin
    o_rx = '0;
    o_rx.level = level_reg;
    o_rx.trigger = 8'h01;
    o_rx.head_err = (level_reg != 8'h00 && err_reg) ? 3'h2 : 3'h0;
    o_rx.push = i_push;
    o_rx.push_err = i_push_err;
    o_rx.pop = i_pop && level_reg != 8'h00;
    o_rx.overrun = i_overrun;
    o_rx.line = i_line;
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      level_reg <= 8'h00;
      err_reg <= 1'b0;
    end
    else
    begin
      level_reg <= level_reg + {7'h00, i_push} - {7'h00, o_rx.pop};
      if (i_push && level_reg == 8'h00)
        err_reg <= i_push_err;
      else if (o_rx.pop)
        err_reg <= 1'b0;
    end
  end
endmodule : uib_peer_model

// File: verification/uib_uart_ctrl_test.sv
// self-checking bench for the uart control core
// assumes a single-entry error history in the peer model is enough
`timescale 1ns/1ps
module uib_uart_ctrl_test;
  import uib_pkg::*;
  // clock starts high so reset falls before the first rising edge
  logic clk = 1'b1;
  logic nrst = 1'b1;
  uib_cfg_t cfg = '0;
  uib_wr_t wr = '0;
  logic [4:0] hp = 5'h00; // iir, lsr, msr, rhr, thr
  uib_tx_t tx = '0;
  uib_evt_t evt = '0;
  uib_rx_t rx;
  logic push = 1'b0, perr = 1'b0, pop = 1'b0, ovr = 1'b0, line = 1'b1;
  logic o_tx, rts_n, dtr_n, rxr_n, txr_n, irq, btick, bittick;
  logic [5:0] ident;
  logic [7:0] line_status_reg;
  logic [3:0] mdelta;
  uib_keep_t keep;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int i;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  uib_peer_model uib_peer_model_i (.i_clk(clk), .i_nrst(nrst), .i_push(push),
    .i_push_err(perr), .i_pop(pop), .i_overrun(ovr), .i_line(line), .o_rx(rx));

  uib_uart_ctrl uib_uart_ctrl_i (.i_clk(clk), .i_nrst(nrst), .i_cfg(cfg), .i_wr(wr),
    .i_rd_iir(hp[0]), .i_rd_lsr(hp[1]), .i_rd_msr(hp[2]), .i_rd_rhr(hp[3]),
    .i_wr_thr(hp[4]), .i_rx(rx), .i_tx(tx), .i_evt(evt), .o_tx(o_tx), .o_rts_n(rts_n),
    .o_dtr_n(dtr_n), .o_rx_dma_ready_n(rxr_n), .o_tx_dma_ready_n(txr_n), .o_irq(irq),
    .o_irq_ident(ident), .o_line_status(line_status_reg), .o_modem_delta(mdelta), .o_keep(keep),
    .o_baud_tick(btick), .o_bit_tick(bittick));

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // hang guard, a full run needs well under 10000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hpulse(input int b);
    @(negedge clk) hp[b] = 1'b1;
    @(negedge clk) hp[b] = 1'b0;
  endtask : hpulse

  task automatic wreg(input int s, input logic [7:0] d);
    @(negedge clk);
    wr.sel = 7'h01 << s;
    wr.data = d;
    @(negedge clk) wr = '0;
  endtask : wreg

  task automatic peer(input logic p, input logic e, input logic q, input logic o);
    @(negedge clk);
    {push, perr, pop, ovr} = {p, e, q, o};
    @(negedge clk) {push, perr, pop, ovr} = 4'h0;
  endtask : peer

  // bounded wait for an ident code, one comparison at the end
  task automatic wait_id(input logic [5:0] code, input int n);
    for (int k = 0; k < n && ident !== code; k++)
      @(negedge clk);
    chk(ident, code, "ident");
  endtask : wait_id

  // cycles between two pulses, zero if none within the bound
  task automatic period(input bit use_bit, input int exp);
    int n;
    n = 0;
    // skip a pulse that is still showing from before
    @(negedge clk);
    for (int k = 0; k < 2000 && (use_bit ? bittick : btick) !== 1'b1; k++)
      @(negedge clk);
    if ((use_bit ? bittick : btick) === 1'b1)
    begin
      do
      begin
        @(negedge clk);
        n++;
      end
      while (n < 2000 && (use_bit ? bittick : btick) !== 1'b1);
    end
    chk(n, exp, "period");
  endtask : period

  task automatic reset_dut;
    @(negedge clk) nrst = 1'b0;
    repeat (3) @(negedge clk);
    chk({o_tx, rts_n, dtr_n, rxr_n, txr_n}, 5'h1E, "reset pins");
    chk(ident, IIR_NONE, "reset ident");
    nrst = 1'b1;
  endtask : reset_dut

  initial
  begin
    reset_dut();
    tx.serial = 1'b1;
    for (i = 0; i < 7; i++)
      wreg(i, 8'hA0 + i[7:0]);
    @(negedge clk);
    reset_dut();
    chk(keep, 56'hA0A1A2A3A4A5A6, "kept regs");
    $display("test keep done");

    cfg.line_control[LCR_BREAK] = 1'b1;
    repeat (2) @(negedge clk);
    chk(o_tx, 1'b0, "break");
    cfg.line_control[LCR_BREAK] = 1'b0;
    repeat (2) @(negedge clk);
    chk(o_tx, 1'b1, "no break");
    $display("test break done");

    cfg.irq_enable = 8'h04;
    peer(0, 0, 0, 1);
    wait_id(IIR_LINE, 4);
    chk(irq, 1'b1, "irq");
    hpulse(1);
    wait_id(IIR_NONE, 4);
    chk(irq, 1'b0, "irq");
    peer(1, 1, 0, 0);
    wait_id(IIR_LINE, 4);
    chk({line_status_reg[LSR_FIFO_ERR], line_status_reg[4:2]}, 4'hA, "err bits");
    peer(0, 0, 1, 0);
    wait_id(IIR_NONE, 4);
    chk({line_status_reg[LSR_FIFO_ERR], line_status_reg[4:2]}, 4'h0, "err cleared");
    $display("test line status done");

    cfg.irq_enable = 8'h01;
    peer(1, 0, 0, 0);
    wait_id(IIR_RXDATA, 4);
    cfg.irq_enable = 8'h10;
    repeat (3) @(negedge clk);
    chk(irq, 1'b0, "irq masked");
    cfg.irq_enable = 8'h01;
    wait_id(IIR_RXDATA, 4);
    cfg.fifo_en = 1'b1;
    wait_id(IIR_NONE, 4);
    peer(1, 0, 0, 0);
    wait_id(IIR_RXDATA, 4);
    peer(0, 0, 1, 0);
    cfg.fifo_en = 1'b0;
    peer(0, 0, 1, 0);
    hpulse(3);
    wait_id(IIR_NONE, 4);
    $display("test rx data done");

    cfg.irq_enable = 8'h02;
    tx.holding_empty = 1'b1;
    wait_id(IIR_TXEMPTY, 4);
    hpulse(0);
    wait_id(IIR_NONE, 4);
    tx.holding_empty = 1'b0;
    @(negedge clk) tx.holding_empty = 1'b1;
    wait_id(IIR_TXEMPTY, 4);
    hpulse(4);
    wait_id(IIR_NONE, 4);
    $display("test tx done");

    cfg.irq_enable = 8'h08;
    @(negedge clk) evt.modem_change = 4'h1;
    @(negedge clk) evt.modem_change = 4'h0;
    wait_id(IIR_MODEM, 4);
    chk(mdelta, 4'h1, "delta");
    hpulse(2);
    wait_id(IIR_NONE, 4);
    cfg.irq_enable = 8'h20;
    @(negedge clk) evt.pause_det = 1'b1;
    @(negedge clk) evt.pause_det = 1'b0;
    wait_id(IIR_FLOWCHR, 4);
    @(negedge clk) evt.resume_det = 1'b1;
    @(negedge clk) evt.resume_det = 1'b0;
    wait_id(IIR_NONE, 4);
    @(negedge clk) evt.special_det = 1'b1;
    @(negedge clk) evt.special_det = 1'b0;
    wait_id(IIR_FLOWCHR, 4);
    hpulse(0);
    wait_id(IIR_NONE, 4);
    cfg.irq_enable = 8'h80;
    @(negedge clk) evt.cts_n = 1'b1;
    wait_id(IIR_PINCHG, 4);
    hpulse(0);
    wait_id(IIR_NONE, 4);
    $display("test events done");

    cfg.irq_enable = 8'h00;
    cfg.line_control = 8'h80;
    wreg(0, 8'h03);
    wreg(1, 8'h00);
    period(0, 3);
    period(1, 48);
    cfg.divisor_fraction = 8'h80;
    period(1, 24);
    period(1, 24);
    cfg.divisor_fraction = 8'h00;
    cfg.modem_control[MCR_PRESCALE] = 1'b1;
    period(0, 12);
    cfg.modem_control[MCR_PRESCALE] = 1'b0;
    cfg.divisor_fraction = 8'h20;
    period(1, 56);
    period(1, 56);
    wreg(0, 8'h00);
    period(0, 0);
    $display("test baud done");

    // one bit time is 16 cycles here, so the 800-cycle wait bound covers 50 bit times, above the 32 of the timeout
    wreg(0, 8'h01);
    cfg.divisor_fraction = 8'h00;
    cfg.irq_enable = 8'h01;
    line = 1'b1;
    peer(1, 0, 0, 0);
    wait_id(IIR_TIMEOUT, 800);
    hpulse(3);
    wait_id(IIR_RXDATA, 4);
    $display("test timeout done");
    give_verdict();
  end
endmodule : uib_uart_ctrl_test
